// [verilog/cos_defines.svh]
`ifndef COS_DEFINES_SVH
`define COS_DEFINES_SVH

`define COS_RESET_PC   16'h0000
`define COS_SP_RESET   8'hff
`define COS_P_RESET    8'h24
`define COS_P_FORCED   8'h20
`define COS_ZERO_PAGE  8'h00
`define COS_STACK_PAGE 8'h01

`define COS_FN 7
`define COS_FV 6
`define COS_FD 3
`define COS_FI 2
`define COS_FZ 1
`define COS_FC 0

`define COS_CYC_RET     3'd6
`define COS_CYC_SBC_IMM 3'd2
`define COS_CYC_STA_IDX 3'd5
`define COS_CYC_ABS_IDX 3'd4
`define COS_CYC_BR_MIN  3'd2
`define COS_CYC_BR_MAX  3'd4
`endif

// [verilog/cos_pkg.sv]
package cos_pkg;

	typedef enum logic [5:0] {
		ST_T0 = 6'h01,
		ST_T1 = 6'h02,
		ST_T2 = 6'h04,
		ST_T3 = 6'h08,
		ST_T4 = 6'h10,
		ST_T5 = 6'h20
	} cos_state_type;

	typedef enum logic [3:0] {
		M_IMP, M_IMM, M_ZP, M_ZPI, M_ABS, M_ABI,
		M_IZX, M_IZY, M_BR, M_JSR, M_RTS, M_RTI
	} cos_mode_type;

	typedef enum logic [3:0] {
		O_NONE, O_BAD, O_SBC, O_STA, O_STX, O_STY, O_A2X, O_A2Y,
		O_S2X, O_X2A, O_X2S, O_Y2A, O_SEC, O_SED, O_SEI
	} cos_op_type;

	typedef struct packed {
		cos_mode_type mode;
		cos_op_type   op;
		logic         use_y;
	} cos_dec_type;

endpackage : cos_pkg

// [verilog/cos_core.sv]
`timescale 1ns/1ps
`include "cos_defines.svh"

module cos_core
	import cos_pkg::*;
#(
	parameter logic [15:0] RESET_PC = `COS_RESET_PC
)(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic [7:0]  mem_rdata,
	output logic      [15:0] mem_addr,
	output logic      [7:0]  mem_wdata,
	output logic             mem_we,
	output logic             sync,
	output logic             bad_opcode,
	output logic      [15:0] pc,
	output logic      [7:0]  acc,
	output logic      [7:0]  x_reg,
	output logic      [7:0]  y_reg,
	output logic      [7:0]  sp,
	output logic      [7:0]  p
);

	cos_state_type state, next_state, adv;
	cos_dec_type   dec;
	logic [7:0]    ir, adl, adh, ptr, idx, stv;
	logic [7:0]    next_ir, next_adl, next_adh, next_ptr, next_acc, next_x, next_y;
	logic [7:0]    next_sp, next_p, next_wdata;
	logic [15:0]   next_pc, next_addr, ea, tgt;
	logic [9:0]    sbc_r;
	logic [8:0]    sum;
	logic          fix, next_fix, next_we, next_sync, next_bad;
	logic          st, flag, go_ea, opnd, idx_step, fix_step;

	function automatic cos_dec_type cos_decode(input logic [7:0] opc);
		cos_dec_type d;
		d = '{M_IMP, O_BAD, 1'b0};
		case (opc)
			8'h60: d = '{M_RTS, O_NONE, 1'b0};
			8'h40: d = '{M_RTI, O_NONE, 1'b0};
			8'h20: d = '{M_JSR, O_NONE, 1'b0};
			8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hb0, 8'hd0, 8'hf0:
				d = '{M_BR, O_NONE, 1'b0};
			8'he9: d = '{M_IMM, O_SBC, 1'b0};
			8'he5: d = '{M_ZP, O_SBC, 1'b0};
			8'hf5: d = '{M_ZPI, O_SBC, 1'b0};
			8'hed: d = '{M_ABS, O_SBC, 1'b0};
			8'hfd: d = '{M_ABI, O_SBC, 1'b0};
			8'hf9: d = '{M_ABI, O_SBC, 1'b1};
			8'he1: d = '{M_IZX, O_SBC, 1'b0};
			8'hf1: d = '{M_IZY, O_SBC, 1'b1};
			8'h38: d = '{M_IMP, O_SEC, 1'b0};
			8'hf8: d = '{M_IMP, O_SED, 1'b0};
			8'h78: d = '{M_IMP, O_SEI, 1'b0};
			8'h85: d = '{M_ZP, O_STA, 1'b0};
			8'h95: d = '{M_ZPI, O_STA, 1'b0};
			8'h8d: d = '{M_ABS, O_STA, 1'b0};
			8'h9d: d = '{M_ABI, O_STA, 1'b0};
			8'h99: d = '{M_ABI, O_STA, 1'b1};
			8'h81: d = '{M_IZX, O_STA, 1'b0};
			8'h91: d = '{M_IZY, O_STA, 1'b1};
			8'h86: d = '{M_ZP, O_STX, 1'b0};
			8'h96: d = '{M_ZPI, O_STX, 1'b1};
			8'h8e: d = '{M_ABS, O_STX, 1'b0};
			8'h84: d = '{M_ZP, O_STY, 1'b0};
			8'h94: d = '{M_ZPI, O_STY, 1'b0};
			8'h8c: d = '{M_ABS, O_STY, 1'b0};
			8'haa: d = '{M_IMP, O_A2X, 1'b0};
			8'ha8: d = '{M_IMP, O_A2Y, 1'b0};
			8'hba: d = '{M_IMP, O_S2X, 1'b0};
			8'h8a: d = '{M_IMP, O_X2A, 1'b0};
			8'h9a: d = '{M_IMP, O_X2S, 1'b0};
			8'h98: d = '{M_IMP, O_Y2A, 1'b0};
			default: ;
		endcase
		return d;
	endfunction : cos_decode

	function automatic logic [7:0] set_nz(input logic [7:0] pv, input logic [7:0] v);
		logic [7:0] r;
		r = pv;
		r[`COS_FN] = v[7];
		r[`COS_FZ] = (v == 8'h00);
		return r;
	endfunction : set_nz

	// Result, carry (no borrow), overflow
	function automatic logic [9:0] sbc_calc(input logic [7:0] a, input logic [7:0] m,
		input logic c, input logic d);
		logic [8:0] bin;
		logic [4:0] lo, hi;
		logic       bo;
		bin = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
		lo = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
		bo = lo[4];
		if (bo)
			lo = lo - 5'h06;
		hi = {1'b0, a[7:4]} - {1'b0, m[7:4]} - {4'h0, bo};
		if (hi[4])
			hi = hi - 5'h06;
		return {d ? {hi[3:0], lo[3:0]} : bin[7:0], ~bin[8],
			(a[7] ^ m[7]) & (a[7] ^ bin[7])};
	endfunction : sbc_calc

	always_comb
	begin
		next_state = cos_state_type'({state[4:0], 1'b0});
		adv        = next_state;
		next_ir    = ir;
		next_pc    = pc;
		next_acc   = acc;
		next_x     = x_reg;
		next_y     = y_reg;
		next_sp    = sp;
		next_p     = p;
		next_adl   = adl;
		next_adh   = adh;
		next_ptr   = ptr;
		next_fix   = fix;
		next_addr  = mem_addr;
		next_wdata = mem_wdata;
		next_we    = 1'b0;
		next_bad   = 1'b0;
		dec        = cos_decode(ir);
		idx        = dec.use_y ? y_reg : x_reg;
		st         = dec.op inside {O_STA, O_STX, O_STY};
		stv        = (dec.op == O_STX) ? x_reg : (dec.op == O_STY) ? y_reg : acc;
		sum        = {1'b0, adl} + {1'b0, idx};
		flag       = ir[7] ? (ir[6] ? p[`COS_FZ] : p[`COS_FC])
			: (ir[6] ? p[`COS_FV] : p[`COS_FN]);
		tgt        = pc + 16'h0001 + {{8{mem_rdata[7]}}, mem_rdata};
		sbc_r      = sbc_calc(acc, mem_rdata, p[`COS_FC], p[`COS_FD]);
		ea         = 16'h0000;
		go_ea      = 1'b0;
		opnd       = 1'b0;
		idx_step   = 1'b0;
		fix_step   = 1'b0;
		unique case (state)
			ST_T0:
			begin
				next_ir   = mem_rdata;
				next_pc   = pc + 16'h0001;
				// T1 reads the byte after the opcode
				next_addr = next_pc;
				next_bad  = (cos_decode(mem_rdata).op == O_BAD);
			end
			ST_T1:
			case (dec.mode)
				M_IMP:
				begin
					next_state = ST_T0;
					case (dec.op)
						O_A2X: begin next_x = acc; next_p = set_nz(p, acc); end
						O_A2Y: begin next_y = acc; next_p = set_nz(p, acc); end
						O_X2A: begin next_acc = x_reg; next_p = set_nz(p, x_reg); end
						O_Y2A: begin next_acc = y_reg; next_p = set_nz(p, y_reg); end
						O_S2X: begin next_x = sp; next_p = set_nz(p, sp); end
						O_X2S: begin next_sp = x_reg; next_p = set_nz(p, x_reg); end
						O_SEC: next_p[`COS_FC] = 1'b1;
						O_SED: next_p[`COS_FD] = 1'b1;
						O_SEI: next_p[`COS_FI] = 1'b1;
						default: ;
					endcase
				end
				M_IMM:
				begin
					next_pc    = pc + 16'h0001;
					opnd       = 1'b1;
					next_state = ST_T0;
				end
				M_ZP:
				begin
					next_pc = pc + 16'h0001;
					go_ea   = 1'b1;
					ea      = {`COS_ZERO_PAGE, mem_rdata};
				end
				M_ZPI, M_ABS, M_ABI:
				begin
					next_adl  = mem_rdata;
					next_pc   = pc + 16'h0001;
					next_addr = (dec.mode == M_ZPI) ? {`COS_ZERO_PAGE, mem_rdata} : next_pc;
				end
				M_IZX, M_IZY:
				begin
					next_ptr  = mem_rdata;
					next_pc   = pc + 16'h0001;
					next_addr = {`COS_ZERO_PAGE, mem_rdata};
				end
				M_BR:
				begin
					next_pc    = pc + 16'h0001;
					{next_adh, next_adl} = tgt;
					next_state = (flag == ir[5]) ? adv : ST_T0;
				end
				M_JSR:
				begin
					next_adl  = mem_rdata;
					next_pc   = pc + 16'h0001;
					next_addr = {`COS_STACK_PAGE, sp};
				end
				default: next_addr = {`COS_STACK_PAGE, sp};
			endcase
			ST_T2:
			case (dec.mode)
				M_ZP: begin opnd = 1'b1; next_state = ST_T0; end
				M_ZPI:
				begin
					go_ea = 1'b1;
					ea    = {`COS_ZERO_PAGE, adl + idx};
				end
				M_ABS:
				begin
					next_pc = pc + 16'h0001;
					go_ea   = 1'b1;
					ea      = {mem_rdata, adl};
				end
				M_ABI:
				begin
					next_pc  = pc + 16'h0001;
					idx_step = 1'b1;
				end
				M_IZX:
				begin
					next_ptr  = ptr + x_reg;
					next_addr = {`COS_ZERO_PAGE, ptr + x_reg};
				end
				M_IZY:
				begin
					next_adl  = mem_rdata;
					next_addr = {`COS_ZERO_PAGE, ptr + 8'h01};
				end
				M_BR:
				begin
					next_pc    = {adh, adl};
					next_state = (adh != pc[15:8]) ? adv : ST_T0;
				end
				M_JSR:
				begin
					next_addr  = {`COS_STACK_PAGE, sp};
					next_we    = 1'b1;
					next_wdata = pc[15:8];
				end
				default:
				begin
					next_sp   = sp + 8'h01;
					next_addr = {`COS_STACK_PAGE, sp + 8'h01};
				end
			endcase
			ST_T3:
			case (dec.mode)
				M_ZPI, M_ABS, M_BR: begin opnd = 1'b1; next_state = ST_T0; end
				M_ABI: fix_step = 1'b1;
				M_IZX:
				begin
					next_adl  = mem_rdata;
					next_addr = {`COS_ZERO_PAGE, ptr + 8'h01};
				end
				M_IZY: idx_step = 1'b1;
				M_JSR:
				begin
					next_sp    = sp - 8'h01;
					next_addr  = {`COS_STACK_PAGE, sp - 8'h01};
					next_we    = 1'b1;
					next_wdata = pc[7:0];
				end
				default:
				begin
					if (dec.mode == M_RTI)
						next_p = mem_rdata | `COS_P_FORCED;
					else
						next_pc = {pc[15:8], mem_rdata};
					next_sp   = sp + 8'h01;
					next_addr = {`COS_STACK_PAGE, sp + 8'h01};
				end
			endcase
			ST_T4:
			case (dec.mode)
				M_IZX:
				begin
					go_ea = 1'b1;
					ea    = {mem_rdata, adl};
				end
				M_IZY: fix_step = 1'b1;
				M_JSR:
				begin
					next_sp   = sp - 8'h01;
					next_addr = pc;
				end
				M_RTS: next_pc = {mem_rdata, pc[7:0]};
				M_RTI:
				begin
					next_pc   = {pc[15:8], mem_rdata};
					next_sp   = sp + 8'h01;
					next_addr = {`COS_STACK_PAGE, sp + 8'h01};
				end
				default: begin opnd = 1'b1; next_state = ST_T0; end
			endcase
			ST_T5:
			begin
				next_state = ST_T0;
				case (dec.mode)
					M_JSR: next_pc = {mem_rdata, adl};
					M_RTS: next_pc = pc + 16'h0001;
					M_RTI: next_pc = {mem_rdata, pc[7:0]};
					default: opnd = 1'b1;
				endcase
			end
		endcase
		// Index add; stores always take the fix-up cycle
		if (idx_step)
		begin
			next_adl = sum[7:0];
			next_adh = mem_rdata + {7'h00, sum[8]};
			next_fix = sum[8] | st;
			if (sum[8] | st)
				next_addr = {mem_rdata, sum[7:0]};
			else
			begin
				go_ea = 1'b1;
				ea    = {mem_rdata, sum[7:0]};
			end
		end
		if (fix_step)
		begin
			if (fix)
			begin
				go_ea = 1'b1;
				ea    = {adh, adl};
			end
			else
			begin
				opnd       = 1'b1;
				next_state = ST_T0;
			end
		end
		if (go_ea)
		begin
			next_addr  = ea;
			next_we    = st;
			next_wdata = stv;
		end
		if (opnd && dec.op == O_SBC)
		begin
			next_acc          = sbc_r[9:2];
			next_p            = set_nz(p, sbc_r[9:2]);
			next_p[`COS_FC]   = sbc_r[1];
			next_p[`COS_FV]   = sbc_r[0];
		end
		if (next_state == ST_T0)
			next_addr = next_pc;
		next_sync = (next_state == ST_T0);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state      <= ST_T0;
			ir         <= 8'h00;
			pc         <= RESET_PC;
			acc        <= 8'h00;
			x_reg      <= 8'h00;
			y_reg      <= 8'h00;
			sp         <= `COS_SP_RESET;
			p          <= `COS_P_RESET;
			adl        <= 8'h00;
			adh        <= 8'h00;
			ptr        <= 8'h00;
			fix        <= 1'b0;
			mem_addr   <= RESET_PC;
			mem_wdata  <= 8'h00;
			mem_we     <= 1'b0;
			sync       <= 1'b1;
			bad_opcode <= 1'b0;
		end
		else if (clk_en)
		begin
			state      <= next_state;
			ir         <= next_ir;
			pc         <= next_pc;
			acc        <= next_acc;
			x_reg      <= next_x;
			y_reg      <= next_y;
			sp         <= next_sp;
			p          <= next_p;
			adl        <= next_adl;
			adh        <= next_adh;
			ptr        <= next_ptr;
			fix        <= next_fix;
			mem_addr   <= next_addr;
			mem_wdata  <= next_wdata;
			mem_we     <= next_we;
			sync       <= next_sync;
			bad_opcode <= next_bad;
		end
	end

	// Cycle count of the instruction just finished
	logic [2:0] len;
	logic       seen;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			len  <= 3'h0;
			seen <= 1'b0;
		end
		else if (clk_en)
		begin
			len  <= (state == ST_T0) ? 3'h1 : len + 3'h1;
			seen <= seen | (state == ST_T0);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_ret_len: assert property (
		seen && state == ST_T0 && dec.mode inside {M_RTS, M_RTI, M_JSR}
		|-> len == `COS_CYC_RET) else $error("return or call length wrong");
	chk_rti_status: assert property (
		clk_en && state == ST_T3 && dec.mode == M_RTI
		|=> p == ($past(mem_rdata) | `COS_P_FORCED)) else $error("status pop wrong");
	chk_sbc_imm: assert property (
		seen && state == ST_T0 && dec.mode == M_IMM && dec.op == O_SBC
		|-> len == `COS_CYC_SBC_IMM) else $error("immediate length wrong");
	chk_flag_set: assert property (
		seen && state == ST_T0 && dec.op == O_SED
		|-> p[`COS_FD]) else $error("decimal flag not set");
	chk_store_len: assert property (
		seen && state == ST_T0 && st && dec.mode == M_ABI
		|-> len == `COS_CYC_STA_IDX) else $error("indexed store length wrong");
	chk_store_write: assert property (
		mem_we |-> st || dec.mode == M_JSR)
		else $error("write from a non-store");
	chk_copy_nz: assert property (
		seen && state == ST_T0 && dec.op == O_A2X
		|-> x_reg == acc && p[`COS_FZ] == (acc == 8'h00)) else $error("copy flags wrong");
	chk_sp_copy: assert property (
		seen && state == ST_T0 && dec.op == O_X2S
		|-> sp == x_reg) else $error("stack pointer copy wrong");
	chk_page_pen: assert property (
		seen && state == ST_T0 && !st && dec.mode == M_ABI
		|-> len == `COS_CYC_ABS_IDX + {2'b00, fix}) else $error("page penalty wrong");
	chk_branch_len: assert property (
		seen && state == ST_T0 && dec.mode == M_BR
		|-> len >= `COS_CYC_BR_MIN && len <= `COS_CYC_BR_MAX) else $error("branch length");
	chk_call_push: assert property (
		state == ST_T3 && dec.mode == M_JSR
		|-> mem_we && mem_wdata == pc[15:8] && mem_addr == {`COS_STACK_PAGE, sp})
		else $error("call push wrong");

	cov_return: cover property (state == ST_T5 && dec.mode == M_RTS);
	cov_cross: cover property (state == ST_T4 && dec.mode == M_ABI && !st);
	cov_br_far: cover property (state == ST_T3 && dec.mode == M_BR);
	cov_dec_sbc: cover property (opnd && dec.op == O_SBC && p[`COS_FD]);

endmodule : cos_core

// [tb/tb_cpu_opcode_subset_decoder.sv]
`timescale 1ns/1ps
module tb_cpu_opcode_subset_decoder;
	logic        clk;
	logic        rst_n;
	logic        clk_en;
	logic [7:0]  mem_rdata;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata;
	logic        mem_we;
	logic        sync;
	logic        bad_opcode;
	logic [15:0] pc;
	logic [7:0]  acc;
	logic [7:0]  x_reg;
	logic [7:0]  y_reg;
	logic [7:0]  sp;
	logic [7:0]  p;
	logic [7:0]  mem [0:65535];
	logic [15:0] e_pc;
	logic [7:0]  e_acc, e_x, e_y, e_sp, e_p;
	logic        saw_bad, e_bad;
	int          fails, checks_done;
	logic [7:0]  ops [21] = '{8'he9, 8'he5, 8'hf5, 8'hed, 8'hfd, 8'hf9, 8'he1, 8'hf1,
		8'h85, 8'h95, 8'h8d, 8'h9d, 8'h99, 8'h81, 8'h91, 8'h86, 8'h96, 8'h8e, 8'h84, 8'h94, 8'h8c};
	int          modes [21] = '{0, 1, 2, 4, 5, 6, 7, 8, 1, 2, 4, 5, 6, 7, 8, 1, 3, 4, 1, 2, 4};
	int          base_cyc [9] = '{2, 3, 4, 4, 4, 4, 4, 6, 5};

	cos_core #(.RESET_PC(16'h8000)) u_cos_core (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
		.mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.sync(sync), .bad_opcode(bad_opcode), .pc(pc), .acc(acc), .x_reg(x_reg),
		.y_reg(y_reg), .sp(sp), .p(p));

	// Combinational memory, written at the end edge
	assign mem_rdata = mem[mem_addr];
	always @(posedge clk)
		if (clk_en && mem_we)
			mem[mem_addr] <= mem_wdata;

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [7:0] nz(input logic [7:0] f, input logic [7:0] v);
		return {v[7], f[6:2], v == 8'h00, f[0]};
	endfunction : nz

	function automatic logic [15:0] subtract_with_borrow(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] f);
		logic [8:0] d;
		d = {1'b0, a} - {1'b0, m} - {8'h00, ~f[0]};
		f[6] = (a[7] ^ m[7]) & (a[7] ^ d[7]);
		f[0] = ~d[8];
		return {d[7:0], nz(f, d[7:0])};
	endfunction : subtract_with_borrow

	task automatic check_state();
		check(pc, e_pc);
		check({8'h00, acc}, {8'h00, e_acc});
		check({8'h00, x_reg}, {8'h00, e_x});
		check({8'h00, y_reg}, {8'h00, e_y});
		check({8'h00, sp}, {8'h00, e_sp});
		check({8'h00, p}, {8'h00, e_p});
		check({15'h0000, saw_bad}, {15'h0000, e_bad});
		e_bad = 1'b0;
	endtask : check_state

	// Places one instruction at the expected pc and counts enabled cycles
	task automatic run_op(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
		input int cyc, input int len);
		int n;
		n = 0;
		saw_bad = 1'b0;
		mem[e_pc] = op;
		mem[e_pc + 16'h1] = b1;
		mem[e_pc + 16'h2] = b2;
		e_pc = e_pc + 16'(len);
		for (int k = 0; k < 40 && !(n > 0 && sync === 1'b1); k++)
		begin
			clk_en = ($urandom % 4) != 0;
			@(posedge clk);
			n += int'(clk_en);
			#1;
			saw_bad |= bad_opcode;
		end
		if (sync !== 1'b1)
		begin
			fails++;
			give_verdict();
		end
		check(16'(n), 16'(cyc));
	endtask : run_op

	task automatic do_reset();
		clk_en = 1'b1;
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
		{e_pc, e_acc, e_x, e_y, e_sp, e_p} = {16'h8000, 24'h000000, 8'hff, 8'h24};
		{e_bad, saw_bad} = 2'b00;
		check_state();
		check({15'h0000, sync}, 16'h0001);
	endtask : do_reset

	task automatic imp(input logic [7:0] op);
		logic [7:0] v;
		logic       t;
		t = 1'b1;
		run_op(op, 8'h00, 8'h00, 2, 1);
		case (op)
			8'haa: {e_x, v} = {e_acc, e_acc};
			8'ha8: {e_y, v} = {e_acc, e_acc};
			8'h8a: {e_acc, v} = {e_x, e_x};
			8'h98: {e_acc, v} = {e_y, e_y};
			8'hba: {e_x, v} = {e_sp, e_sp};
			8'h9a: {e_sp, v} = {e_x, e_x};
			default:
			begin
				t = 1'b0;
				v = 8'h00;
				e_p = e_p | (op == 8'h38 ? 8'h01 : op == 8'hf8 ? 8'h08 : op == 8'h78 ? 8'h04 : 8'h00);
				e_bad = op == 8'hea;
			end
		endcase
		if (t)
			e_p = nz(e_p, v);
		check_state();
	endtask : imp

	task automatic imm(input logic [7:0] m);
		run_op(8'he9, m, 8'h00, 2, 2);
		{e_acc, e_p} = subtract_with_borrow(e_acc, m, e_p);
		check_state();
	endtask : imm

	task automatic return_from_interrupt(input logic [7:0] pv);
		logic [15:0] t;
		t = e_pc + 16'h0100;
		mem[{8'h01, 8'(e_sp + 8'h1)}] = pv;
		mem[{8'h01, 8'(e_sp + 8'h2)}] = t[7:0];
		mem[{8'h01, 8'(e_sp + 8'h3)}] = t[15:8];
		run_op(8'h40, 8'h00, 8'h00, 6, 1);
		{e_pc, e_sp, e_p} = {t, 8'(e_sp + 8'h3), pv | 8'h20};
		check_state();
	endtask : return_from_interrupt

	// Operand bytes and effective address for one addressing mode
	task automatic prep(input int md, output logic [7:0] b1, output logic [7:0] b2,
		output logic [15:0] ea, output int cr);
		logic [7:0] zp, lo, hi, ix;
		zp = 8'($urandom);
		lo = 8'($urandom);
		hi = 8'h20 + 8'($urandom % 80);
		ix = (md == 3 || md == 6 || md == 8) ? e_y : e_x;
		b1 = (md >= 4 && md <= 6) ? lo : zp;
		b2 = hi;
		case (md)
			0: ea = 16'h0000;
			1: ea = {8'h00, zp};
			2, 3: ea = {8'h00, 8'(zp + ix)};
			4: ea = {hi, lo};
			5, 6: ea = {hi, lo} + {8'h00, ix};
			7:
			begin
				mem[{8'h00, 8'(zp + ix)}] = lo;
				mem[{8'h00, 8'(zp + ix + 8'h1)}] = hi;
				ea = {hi, lo};
			end
			default:
			begin
				mem[{8'h00, zp}] = lo;
				mem[{8'h00, 8'(zp + 8'h1)}] = hi;
				ea = {hi, lo} + {8'h00, ix};
			end
		endcase
		cr = int'((md == 5 || md == 6 || md == 8) && (16'(lo) + 16'(ix) > 16'h00ff));
	endtask : prep

	initial
	begin
		int          md, cr;
		logic        st;
		logic [7:0]  m, b1, b2;
		logic [15:0] ea, tgt, ret, nx;
		void'($urandom(46278));
		rst_n = 1'b0;
		clk_en = 1'b1;
		fails = 0;
		checks_done = 0;
		for (int a = 0; a < 65536; a++)
			mem[a] = 8'($urandom);
		do_reset();
		for (int k = 0; k < 4; k++)
		begin
			imp(8'h38);
			imm(8'($urandom));
			imp(8'haa);
			imm(8'($urandom));
			imp(8'ha8);
			for (int i = 0; i < 21; i++)
			begin
				md = modes[i];
				m = 8'($urandom);
				prep(md, b1, b2, ea, cr);
				st = ops[i][7:5] != 3'b111;
				if (md == 0)
					b1 = m;
				else
					mem[ea] = m;
				if (st)
					cr = int'(md == 5 || md == 6 || md == 8);
				run_op(ops[i], b1, b2, base_cyc[md] + cr, (md >= 4 && md <= 6) ? 3 : 2);
				if (!st)
					{e_acc, e_p} = subtract_with_borrow(e_acc, m, e_p);
				else
					check({8'h00, mem[ea]}, {8'h00, ops[i][1:0] == 2'b01 ? e_acc :
						ops[i][1] ? e_x : e_y});
				check_state();
			end
		end
		imp(8'haa);
		imp(8'ha8);
		imp(8'h8a);
		imp(8'h98);
		imp(8'hba);
		imp(8'h9a);
		return_from_interrupt(8'h00);
		imm(8'(e_acc - 8'h51));
		imp(8'h38);
		imp(8'hf8);
		imp(8'h78);
		// Decimal borrow: 50 minus 25 gives 25
		run_op(8'he9, 8'h25, 8'h00, 2, 2);
		e_acc = 8'h25;
		e_p = (e_p & 8'h3c) | 8'h01;
		check_state();
		return_from_interrupt(8'hd3);
		tgt = e_pc + 16'h0200;
		ret = e_pc + 16'h0002;
		run_op(8'h20, tgt[7:0], tgt[15:8], 6, 3);
		check({8'h00, mem[{8'h01, e_sp}]}, {8'h00, ret[15:8]});
		check({8'h00, mem[{8'h01, 8'(e_sp - 8'h1)}]}, {8'h00, ret[7:0]});
		{e_pc, e_sp} = {tgt, 8'(e_sp - 8'h2)};
		check_state();
		run_op(8'h60, 8'h00, 8'h00, 6, 1);
		{e_pc, e_sp} = {ret + 16'h0001, 8'(e_sp + 8'h2)};
		check_state();
		run_op(8'h90, 8'h10, 8'h00, 2, 2);
		check_state();
		for (int i = 0; i < 8; i++)
		begin
			nx = e_pc + 16'h0002;
			m = (i == 0) ? (nx[7] ? 8'h7f : 8'h80) : 8'($urandom);
			tgt = nx + {{8{m[7]}}, m};
			run_op(8'hb0, m, 8'h00, 3 + int'(tgt[15:8] != nx[15:8]), 2);
			e_pc = tgt;
			check_state();
		end
		imp(8'hea);
		do_reset();
		give_verdict();
	end
endmodule : tb_cpu_opcode_subset_decoder
